// *** hdl/mss_spi_port.sv ***
`timescale 1ns/1ns
module mss_spi_port import mss_pkg::*; #(
  parameter int FAST_PERIOD_P = FAST_PERIOD_CYCLES,
  parameter int SECOND_P      = SECOND_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       spiClk,
  input  wire logic       chipSelN,
  input  wire logic       serialIn,
  output logic            serialOut,
  output logic            serialOutOe,
  input  wire logic       sdioIn,
  output logic            sdioOut,
  output logic            sdioOe,
  input  wire logic [7:0] accelMagnitude,
  input  wire logic       accelValid,
  output logic            measureActive,
  output logic            sleepActive,
  output logic            lowPowerSample,
  output logic [3:0]      rateCode,
  output logic            sampleTick,
  output logic            i2cMode
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic sclkS;
  logic csnS;
  logic sdiS;
  logic sdioS;

  mss_sync #(.RESET_VAL(1'b1)) uSyncClk (.clk_sys(clk_sys), .reset_n(reset_n),
                                         .asyncIn(spiClk), .syncOut(sclkS));
  mss_sync #(.RESET_VAL(1'b1)) uSyncCs  (.clk_sys(clk_sys), .reset_n(reset_n),
                                         .asyncIn(chipSelN), .syncOut(csnS));
  mss_sync #(.RESET_VAL(1'b0)) uSyncDi  (.clk_sys(clk_sys), .reset_n(reset_n),
                                         .asyncIn(serialIn), .syncOut(sdiS));
  mss_sync #(.RESET_VAL(1'b0)) uSyncDio (.clk_sys(clk_sys), .reset_n(reset_n),
                                         .asyncIn(sdioIn), .syncOut(sdioS));

  // ****************************************
  // state
  // ****************************************
  logic [7:0]  inactThresh;
  logic [7:0]  inactTime;
  logic [7:0]  ratePower;
  logic [7:0]  powerCtrl;
  logic [7:0]  outFormat;
  logic        sclkPrev;
  mss_phase_t  phase;
  logic [2:0]  bitCount;
  logic [7:0]  shiftIn;
  logic [7:0]  shiftOut;
  logic        outBit;
  logic        readFlag;
  logic        burstFlag;
  logic        dataOpen;
  logic [5:0]  regPtr;
  logic        sleeping;
  logic        quiet;
  logic [31:0] secCount;
  logic [7:0]  inactSec;
  logic [31:0] sampleCount;
  logic        tick;
  logic        i2cSel;

  logic [7:0]  next_inactThresh;
  logic [7:0]  next_inactTime;
  logic [7:0]  next_ratePower;
  logic [7:0]  next_powerCtrl;
  logic [7:0]  next_outFormat;
  mss_phase_t  next_phase;
  logic [2:0]  next_bitCount;
  logic [7:0]  next_shiftIn;
  logic [7:0]  next_shiftOut;
  logic        next_outBit;
  logic        next_readFlag;
  logic        next_burstFlag;
  logic        next_dataOpen;
  logic [5:0]  next_regPtr;
  logic        next_sleeping;
  logic        next_quiet;
  logic [31:0] next_secCount;
  logic [7:0]  next_inactSec;
  logic [31:0] next_sampleCount;
  logic        next_tick;
  logic        next_i2cSel;

  logic        sclkRise;
  logic        sclkFall;
  logic        csActive;
  logic        threeWire;
  logic        inBit;
  logic [7:0]  capByte;
  logic        regWe;
  logic        measuring;
  logic        autoArmed;
  logic [3:0]  codeEff;
  logic [31:0] periodCycles;

  assign sclkRise  = sclkS & ~sclkPrev;
  assign sclkFall  = ~sclkS & sclkPrev;
  assign csActive  = ~csnS;
  assign threeWire = outFormat[SPI3_BIT];
  assign inBit     = threeWire ? sdioS : sdiS;
  assign capByte   = {shiftIn[6:0], inBit};
  assign measuring = powerCtrl[MEASURE_BIT];
  assign autoArmed = powerCtrl[AUTOSLEEP_BIT] & powerCtrl[LINK_BIT];

  // register map read; no mode gate, so standby reads everything
  function automatic logic [7:0] regValue(input logic [5:0] addr);
    case (addr)
      ADDR_INACT_THRESH: regValue = inactThresh;
      ADDR_INACT_TIME:   regValue = inactTime;
      ADDR_RATE_POWER:   regValue = ratePower;
      ADDR_POWER_CTRL:   regValue = powerCtrl;
      ADDR_OUT_FORMAT:   regValue = outFormat;
      ADDR_MODE_STATUS:  regValue = {6'h00, sleeping, measuring};
      default:           regValue = 8'h00;
    endcase
  endfunction

  // ****************************************
  // serial engine
  // ****************************************
  always_comb begin
    next_phase     = phase;
    next_bitCount  = bitCount;
    next_shiftIn   = shiftIn;
    next_shiftOut  = shiftOut;
    next_outBit    = outBit;
    next_readFlag  = readFlag;
    next_burstFlag = burstFlag;
    next_dataOpen  = dataOpen;
    next_regPtr    = regPtr;
    next_i2cSel    = i2cSel & ~csActive;
    regWe          = 1'b0;
    if (!csActive) begin
      next_phase    = PH_IDLE;
      next_bitCount = 3'h0;
      next_outBit   = 1'b0;
    end else begin
      if (phase == PH_IDLE) begin
        next_phase = PH_ADDR;
      end
      // sample on rise, shift out on fall: mode 1,1
      if (sclkRise && phase != PH_IDLE) begin
        next_shiftIn  = capByte;
        next_bitCount = bitCount + 3'h1;
        if (bitCount == LAST_BIT) begin
          if (phase == PH_ADDR) begin
            next_readFlag  = capByte[READ_FLAG_BIT];
            next_burstFlag = capByte[BURST_FLAG_BIT];
            next_regPtr    = capByte[5:0];
            next_phase     = PH_DATA;
            next_dataOpen  = 1'b1;
            next_shiftOut  = regValue(capByte[5:0]);
          end else begin
            regWe         = ~readFlag & dataOpen;
            next_dataOpen = burstFlag;
            if (burstFlag) begin
              next_regPtr   = regPtr + 6'h01;
              next_shiftOut = regValue(regPtr + 6'h01);
            end else begin
              next_shiftOut = 8'h00;
            end
          end
        end
      end
      if (sclkFall && phase == PH_DATA) begin
        next_outBit   = shiftOut[7];
        next_shiftOut = {shiftOut[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sclkPrev  <= 1'b1;
      phase     <= PH_IDLE;
      bitCount  <= 3'h0;
      shiftIn   <= 8'h00;
      shiftOut  <= 8'h00;
      outBit    <= 1'b0;
      readFlag  <= 1'b0;
      burstFlag <= 1'b0;
      dataOpen  <= 1'b0;
      regPtr    <= 6'h00;
      i2cSel    <= 1'b1;
    end else begin
      sclkPrev  <= sclkS;
      phase     <= next_phase;
      bitCount  <= next_bitCount;
      shiftIn   <= next_shiftIn;
      shiftOut  <= next_shiftOut;
      outBit    <= next_outBit;
      readFlag  <= next_readFlag;
      burstFlag <= next_burstFlag;
      dataOpen  <= next_dataOpen;
      regPtr    <= next_regPtr;
      i2cSel    <= next_i2cSel;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  always_comb begin
    next_inactThresh = inactThresh;
    next_inactTime   = inactTime;
    next_ratePower   = ratePower;
    next_powerCtrl   = powerCtrl;
    next_outFormat   = outFormat;
    if (regWe) begin
      case (regPtr)
        ADDR_INACT_THRESH: next_inactThresh = capByte;
        ADDR_INACT_TIME:   next_inactTime   = capByte;
        ADDR_RATE_POWER:   next_ratePower   = capByte;
        ADDR_POWER_CTRL:   next_powerCtrl   = capByte;
        ADDR_OUT_FORMAT:   next_outFormat   = capByte;
        default:           next_outFormat   = outFormat;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      inactThresh <= RST_INACT_THRESH;
      inactTime   <= RST_INACT_TIME;
      ratePower   <= RST_RATE_POWER;
      powerCtrl   <= RST_POWER_CTRL;
      outFormat   <= RST_OUT_FORMAT;
    end else begin
      inactThresh <= next_inactThresh;
      inactTime   <= next_inactTime;
      ratePower   <= next_ratePower;
      powerCtrl   <= next_powerCtrl;
      outFormat   <= next_outFormat;
    end
  end

  // ****************************************
  // power modes and sampling
  // ****************************************
  // codes below the slowest rate are clamped to it
  assign codeEff = (ratePower[3:0] < RATE_CODE_MIN) ? RATE_CODE_MIN : ratePower[3:0];
  assign periodCycles = 32'(FAST_PERIOD_P) << (RATE_CODE_MAX - codeEff);

  always_comb begin
    next_sampleCount = sampleCount;
    next_tick        = 1'b0;
    next_quiet       = quiet;
    next_secCount    = secCount;
    next_inactSec    = inactSec;
    next_sleeping    = sleeping;
    // standby stops the sample and inactivity timers and clears sleeping; nothing here flushes stored samples
    if (!measuring) begin
      next_sampleCount = 32'h0000_0000;
    end else if (sampleCount >= periodCycles - 32'h0000_0001) begin
      next_sampleCount = 32'h0000_0000;
      next_tick        = 1'b1;
    end else begin
      next_sampleCount = sampleCount + 32'h0000_0001;
    end
    if (accelValid) begin
      next_quiet = (accelMagnitude <= inactThresh);
    end
    if (!measuring || !next_quiet) begin
      next_secCount = 32'h0000_0000;
      next_inactSec = 8'h00;
    end else if (secCount >= 32'(SECOND_P) - 32'h0000_0001) begin
      next_secCount = 32'h0000_0000;
      next_inactSec = (inactSec == 8'hFF) ? inactSec : inactSec + 8'h01;
    end else begin
      next_secCount = secCount + 32'h0000_0001;
    end
    if (!measuring || !autoArmed || !next_quiet) begin
      next_sleeping = 1'b0;
    end else if (inactSec >= inactTime) begin
      next_sleeping = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sampleCount <= 32'h0000_0000;
      tick        <= 1'b0;
      quiet       <= 1'b0;
      secCount    <= 32'h0000_0000;
      inactSec    <= 8'h00;
      sleeping    <= 1'b0;
    end else begin
      sampleCount <= next_sampleCount;
      tick        <= next_tick;
      quiet       <= next_quiet;
      secCount    <= next_secCount;
      inactSec    <= next_inactSec;
      sleeping    <= next_sleeping;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign measureActive  = measuring;
  assign sleepActive    = sleeping;
  assign lowPowerSample = measuring & ratePower[LOW_POWER_BIT];
  assign rateCode       = ratePower[3:0];
  assign sampleTick     = tick;
  assign i2cMode        = i2cSel;
  assign serialOut      = outBit;
  assign sdioOut        = outBit;
  // 4-wire drives its output through every frame; write data is don't-care
  assign serialOutOe    = ~threeWire & csActive;
  assign sdioOe         = threeWire & csActive & (phase == PH_DATA) & readFlag;

  // ****************************************
  // assertions
  // ****************************************
  logic pcWrite;
  assign pcWrite = regWe && regPtr == ADDR_POWER_CTRL;

  reset_standby_a: assert property (@(posedge clk_sys)
    !reset_n |=> !measureActive && !sampleTick)
    else $error("device not in standby after reset");

  measure_entry_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pcWrite && capByte[MEASURE_BIT] |=> measureActive)
    else $error("measure write did not start measuring");

  standby_return_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pcWrite && !capByte[MEASURE_BIT] |=> !measureActive ##1 !sleepActive)
    else $error("clearing measure bit did not give standby");

  standby_no_tick_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !measureActive |=> !sampleTick)
    else $error("sample taken in standby");

  sdio_release_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sdioOe |-> threeWire && readFlag && phase == PH_DATA && !serialOutOe)
    else $error("shared line driven outside read data");

  four_wire_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    serialOutOe |-> !outFormat[SPI3_BIT] && !csnS)
    else $error("output driven in 3-wire mode or while deselected");

  burst_step_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sclkRise && phase == PH_DATA && bitCount == LAST_BIT && burstFlag && !csnS
    |=> regPtr == $past(regPtr) + 6'h01)
    else $error("burst pointer did not advance");

  single_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    phase == PH_DATA && !burstFlag && !dataOpen |-> !regWe)
    else $error("write beyond one byte without burst flag");

  shift_on_fall_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    csActive && $changed(outBit) |-> $past(sclkFall))
    else $error("output bit changed away from falling edge");

  sleep_entry_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    measuring && autoArmed && quiet && !accelValid && inactSec >= inactTime |=> sleepActive)
    else $error("autosleep not entered");

  burst_read_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    readFlag && burstFlag && phase == PH_DATA ##1 regPtr != $past(regPtr));
  three_wire_read_c: cover property (@(posedge clk_sys) disable iff (!reset_n) sdioOe);
  sleep_c: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(sleepActive));
  measure_c: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(measureActive));

endmodule // mss_spi_port

// *** hdl/mss_pkg.sv ***
// Notes on behaviour
// - powers up in standby, no measuring
// - measure bit set enters measurement mode
// - measure bit 3 cleared returns standby
// - standby makes no acceleration measurements
// - standby entry leaves sample FIFO untouched
// - all registers readable and writable in standby
// - low-power bit 4 reduces internal sampling
// - rate code 1111 is 3200 Hz, halving
// - inactivity threshold sets no-activity level
// - autosleep plus link and quiet time sleeps
// - chip select held high selects I2C
// - SPI bit clear 4-wire, set 3-wire
// - clock polarity 1, phase 1, max 5 MHz; the testbench master clocks at 6.25 MHz (160 ns period)
// - clock idles high, shift fall, sample rise
// - burst beyond one byte needs burst flag
// - each further byte advances register pointer
package mss_pkg;

  // ****************************************
  // clocking and timing
  // ****************************************
  localparam int CLK_HZ             = 50_000_000;
  localparam int SPI_MAX_HZ         = 5_000_000;
  localparam int FASTEST_RATE_HZ    = 3200;
  localparam int INACT_UNIT_S       = 1;
  localparam int FAST_PERIOD_CYCLES = CLK_HZ / FASTEST_RATE_HZ;
  localparam int SECOND_CYCLES      = CLK_HZ * INACT_UNIT_S;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [5:0] ADDR_INACT_THRESH = 6'h25;
  localparam logic [5:0] ADDR_INACT_TIME   = 6'h26;
  localparam logic [5:0] ADDR_RATE_POWER   = 6'h2C;
  localparam logic [5:0] ADDR_POWER_CTRL   = 6'h2D;
  localparam logic [5:0] ADDR_OUT_FORMAT   = 6'h31;
  localparam logic [5:0] ADDR_MODE_STATUS  = 6'h3F;

  // ****************************************
  // field positions and codes
  // ****************************************
  localparam int MEASURE_BIT    = 3;
  localparam int AUTOSLEEP_BIT  = 4;
  localparam int LINK_BIT       = 5;
  localparam int LOW_POWER_BIT  = 4;
  localparam int SPI3_BIT       = 6;
  localparam int READ_FLAG_BIT  = 7;
  localparam int BURST_FLAG_BIT = 6;
  localparam logic [3:0] RATE_CODE_MAX = 4'hF;
  localparam logic [3:0] RATE_CODE_MIN = 4'h6;
  localparam logic [2:0] LAST_BIT      = 3'h7;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [7:0] RST_INACT_THRESH = 8'h00;
  localparam logic [7:0] RST_INACT_TIME   = 8'h00;
  localparam logic [7:0] RST_RATE_POWER   = 8'h0A;
  localparam logic [7:0] RST_POWER_CTRL   = 8'h00;
  localparam logic [7:0] RST_OUT_FORMAT   = 8'h00;

  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} mss_phase_t;

endpackage

// *** hdl/mss_sync.sv ***
`timescale 1ns/1ns
module mss_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic stageOne;

  // ****************************************
  // two-stage synchroniser
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stageOne <= RESET_VAL;
      syncOut  <= RESET_VAL;
    end else begin
      stageOne <= asyncIn;
      syncOut  <= stageOne;
    end
  end
endmodule // mss_sync

// *** sim/mss_spi_master.sv ***
`timescale 1ns/1ns
module mss_spi_master (
  input  wire logic clk_sys,
  input  wire logic misoLine,
  output logic      spiClk,
  output logic      chipSelN,
  output logic      mosiBit,
  output logic      mosiOe,
  output logic      threeWire
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];

  initial begin
    spiClk    = 1'b1; // idles high
    chipSelN  = 1'b1;
    mosiBit   = 1'b0;
    mosiOe    = 1'b0;
    threeWire = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // ****************************************
  // one framed transfer
  // ****************************************
  task automatic xfer(input logic [7:0] hdr, input int nData, input logic three);
    logic [7:0] tx;
    logic [7:0] rx;
    threeWire <= three;
    chipSelN  <= 1'b0;
    tick(4);
    for (int b = 0; b <= nData; b++) begin
      tx = (b == 0) ? hdr : (hdr[7] ? 8'h00 : txq.pop_front());
      for (int i = 7; i >= 0; i--) begin
        spiClk  <= 1'b0;
        mosiBit <= tx[i];
        mosiOe  <= !(three && hdr[7] && b > 0);
        tick(4);
        spiClk <= 1'b1; // 160 ns period
        tick(2);
        rx[i] = misoLine;
        if (three && hdr[7] && b == 0 && i == 0) begin
          mosiOe <= 1'b0; // free the shared line after the last address bit
        end
        tick(2);
      end
      if (hdr[7] && b > 0) begin
        rxq.push_back(rx); // write replies dropped
      end
    end
    chipSelN <= 1'b1;
    mosiOe   <= 1'b0;
    tick(8);
  endtask
endmodule // mss_spi_master

// *** sim/tb_spi_port_power_modes.sv ***
`timescale 1ns/1ns
module tb_spi_port_power_modes import mss_pkg::*;;
  localparam int FAST_P = 8;
  localparam int SEC_P  = 20;
  localparam logic [5:0] REGS [6] = '{ADDR_INACT_THRESH, ADDR_INACT_TIME,
    ADDR_RATE_POWER, ADDR_POWER_CTRL, ADDR_OUT_FORMAT, 6'h00};

  logic       clk_sys        = 1'b0;
  logic       reset_n        = 1'b0;
  logic [7:0] accelMagnitude = 8'h00;
  logic       accelValid     = 1'b0;
  logic       loud           = 1'b0;
  logic       useThree       = 1'b0;
  logic       lastSer        = 1'b0;
  logic       lastSdio       = 1'b0;
  logic       lastMiso       = 1'b0;
  logic       spiClk, chipSelN, mosiBit, mosiOe, threeWire, lp;
  logic       serialOut, serialOutOe, sdioOut, sdioOe, sampleTick, i2cMode;
  logic       measureActive, sleepActive, lowPowerSample;
  logic [3:0] rateCode;
  logic [7:0] shadow [64];
  logic [7:0] rdv;
  int         err_count = 0;
  int         checked   = 0;
  int         seed      = 32'h2c0443dd;
  int         cyc       = 0;
  int         ticks     = 0;
  int         t0, t1;
  // released lines float: show the inverse of the last driven level
  wire        serialIn = mosiOe ? mosiBit : ~lastSer;
  wire        sdioIn   = sdioOe ? sdioOut : (mosiOe ? mosiBit : ~lastSdio);
  wire        misoLine = threeWire ? sdioIn : (serialOutOe ? serialOut : ~lastMiso);

  always #10 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    lastSer        <= mosiOe ? mosiBit : lastSer;
    lastSdio       <= (sdioOe || mosiOe) ? sdioIn : lastSdio;
    lastMiso       <= serialOutOe ? serialOut : lastMiso;
    accelValid     <= (cyc % 8 == 0);
    accelMagnitude <= loud ? 8'h41 : 8'($unsigned($random(seed)) % 65);
    if (sampleTick === 1'b1) ticks++;
    if (sdioOe === 1'b1 && (mosiOe || !threeWire)) begin
      err_count++;
      $display("[ERR] sdioOe expected 0 seen 1");
    end
  end

  mss_spi_port #(.FAST_PERIOD_P(FAST_P), .SECOND_P(SEC_P)) mss_spi_port_inst (
    .clk_sys        (clk_sys),
    .reset_n        (reset_n),
    .spiClk         (spiClk),
    .chipSelN       (chipSelN),
    .serialIn       (serialIn),
    .serialOut      (serialOut),
    .serialOutOe    (serialOutOe),
    .sdioIn         (sdioIn),
    .sdioOut        (sdioOut),
    .sdioOe         (sdioOe),
    .accelMagnitude (accelMagnitude),
    .accelValid     (accelValid),
    .measureActive  (measureActive),
    .sleepActive    (sleepActive),
    .lowPowerSample (lowPowerSample),
    .rateCode       (rateCode),
    .sampleTick     (sampleTick),
    .i2cMode        (i2cMode)
  );

  mss_spi_master mss_spi_master_inst (
    .clk_sys   (clk_sys),
    .misoLine  (misoLine),
    .spiClk    (spiClk),
    .chipSelN  (chipSelN),
    .mosiBit   (mosiBit),
    .mosiOe    (mosiOe),
    .threeWire (threeWire)
  );

  // ****************************************
  // checks and bus tasks
  // ****************************************
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmpb(input string what, input logic exp, input logic got);
    cmp(what, {15'h0, exp}, {15'h0, got});
  endtask

  task automatic timeout(input string what);
    err_count++;
    $display("[ERR] %s expected change seen none", what);
    give_verdict();
  endtask

  function automatic logic [7:0] expect_reg(input logic [5:0] a);
    case (a)
      ADDR_INACT_THRESH, ADDR_INACT_TIME, ADDR_RATE_POWER,
        ADDR_POWER_CTRL, ADDR_OUT_FORMAT: return shadow[a];
      ADDR_MODE_STATUS: return {7'h00, shadow[ADDR_POWER_CTRL][MEASURE_BIT]};
      default: return 8'h00;
    endcase
  endfunction

  function automatic int gap_of(input int code);
    return FAST_P << (15 - (code < 6 ? 6 : code));
  endfunction

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    shadow[a] = d;
    mss_spi_master_inst.txq.push_back(d);
    mss_spi_master_inst.xfer({2'b00, a}, 1, useThree);
  endtask

  task automatic rdchk(input logic [5:0] a);
    mss_spi_master_inst.xfer({2'b10, a}, 1, useThree);
    rdv = mss_spi_master_inst.rxq.pop_front();
    cmp("register", {8'h00, expect_reg(a)}, {8'h00, rdv});
  endtask

  task automatic wait_tick(output int at);
    int k;
    for (k = 0; k < 5000; k++) begin
      @(negedge clk_sys);
      if (sampleTick === 1'b1) break;
    end
    at = cyc;
    if (k == 5000) timeout("sampleTick");
  endtask

  task automatic wait_sleep(input logic v, input int lim);
    int k;
    checked++;
    for (k = 0; k < lim; k++) begin
      @(negedge clk_sys);
      if (sleepActive === v) break;
    end
    if (k == lim) timeout("sleepActive");
  endtask

  task automatic give_verdict;
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    timeout("run");
  end

  initial begin
    foreach (shadow[i]) shadow[i] = 8'h00;
    shadow[ADDR_INACT_THRESH] = RST_INACT_THRESH;
    shadow[ADDR_INACT_TIME]   = RST_INACT_TIME;
    shadow[ADDR_RATE_POWER]   = RST_RATE_POWER;
    shadow[ADDR_POWER_CTRL]   = RST_POWER_CTRL;
    shadow[ADDR_OUT_FORMAT]   = RST_OUT_FORMAT;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(negedge clk_sys);
    cmp("rateCode", {12'h0, RST_RATE_POWER[3:0]}, {12'h0, rateCode});
    cmpb("measureActive", 1'b0, measureActive);
    cmpb("sleepActive", 1'b0, sleepActive);
    cmpb("i2cMode", 1'b1, i2cMode);
    foreach (REGS[i]) rdchk(REGS[i]);
    cmpb("i2cMode", 1'b0, i2cMode);
    foreach (REGS[i]) begin
      wr(REGS[i], 8'($random(seed)) & (REGS[i] == ADDR_POWER_CTRL ? 8'hC7 : 8'hBF));
      rdchk(REGS[i]);
    end
    cmp("ticks", 16'h0, 16'(ticks));
    rdv = 8'($random(seed));
    mss_spi_master_inst.txq = '{rdv, ~rdv};
    mss_spi_master_inst.xfer({2'b01, ADDR_INACT_THRESH}, 2, useThree);
    shadow[ADDR_INACT_THRESH] = rdv;
    shadow[ADDR_INACT_TIME]   = ~rdv;
    mss_spi_master_inst.xfer({2'b11, ADDR_INACT_THRESH}, 3, useThree);
    for (int a = 0; a < 3; a++) begin
      rdv = mss_spi_master_inst.rxq.pop_front();
      cmp("burst", {8'h0, expect_reg(ADDR_INACT_THRESH + 6'(a))}, {8'h0, rdv});
    end
    // flag clear: the second data byte must be dropped
    mss_spi_master_inst.txq = '{8'h5A, 8'hA5};
    mss_spi_master_inst.xfer({2'b00, ADDR_INACT_THRESH}, 2, useThree);
    shadow[ADDR_INACT_THRESH] = 8'h5A;
    rdchk(ADDR_INACT_THRESH);
    rdchk(ADDR_INACT_TIME);
    wr(ADDR_POWER_CTRL, 8'h08); // configured first
    @(negedge clk_sys);
    cmpb("measureActive", 1'b1, measureActive);
    rdchk(ADDR_MODE_STATUS);
    for (int c = 6; c < 16; c++) begin
      lp = (c >= 7 && c <= 12) ? 1'($random(seed)) : 1'b0;
      wr(ADDR_RATE_POWER, {3'b000, lp, 4'(c)});
      @(negedge clk_sys);
      cmp("rateCode", 16'(c), {12'h0, rateCode});
      cmpb("lowPowerSample", lp, lowPowerSample);
      wait_tick(t0);
      wait_tick(t1);
      cmp("tickGap", 16'(gap_of(c)), 16'(t1 - t0));
    end
    wr(ADDR_POWER_CTRL, 8'h00);
    @(negedge clk_sys);
    cmpb("measureActive", 1'b0, measureActive);
    t0 = ticks;
    repeat (600) @(negedge clk_sys);
    cmp("ticks", 16'(t0), 16'(ticks));
    wr(ADDR_INACT_THRESH, 8'h40);
    wr(ADDR_INACT_TIME, 8'h01);
    wr(ADDR_POWER_CTRL, 8'h18);
    repeat (100) @(negedge clk_sys);
    cmpb("sleepActive", 1'b0, sleepActive);
    wr(ADDR_POWER_CTRL, 8'h38);
    wait_sleep(1'b1, 200);
    loud = 1'b1;
    wait_sleep(1'b0, 40);
    loud = 1'b0;
    // mid-run reset while measuring
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(negedge clk_sys);
    cmpb("measureActive", 1'b0, measureActive);
    cmpb("sleepActive", 1'b0, sleepActive);
    cmpb("i2cMode", 1'b1, i2cMode);
    cmp("rateCode", {12'h0, RST_RATE_POWER[3:0]}, {12'h0, rateCode});
    wr(ADDR_POWER_CTRL, 8'h00);
    wr(ADDR_OUT_FORMAT, 8'h40);
    useThree = 1'b1;
    wr(ADDR_INACT_TIME, 8'($random(seed)));
    rdchk(ADDR_INACT_TIME);
    rdchk(ADDR_OUT_FORMAT);
    give_verdict();
  end
endmodule // tb_spi_port_power_modes
